/* cem_defs.svh */
// Notes on behaviour
// - Each source holds one of four states
// - Inactive means neither pending nor active
// - Line or software request sets pending
// - Nested handlers stay active together
// - Request while active gives active-and-pending
// - Reset halts; restart fetches vector 0x04
// - Restart privileged in thread mode
// - Nonmaskable: priority -2, vector 0x08, unmaskable
// - Hard fault: priority -1, vector 0x0C
// - Protection fault, execute-never always aborts, 0x10
// - Bus fault precise sync, imprecise async
// - Usage fault causes, vector 0x18
// - Optional unaligned and divide-zero usage faults
// - Supervisor call synchronous, vector 0x2C
// - Pended service request asynchronous, vector 0x38
// - System tick on timer zero, 0x3C
// - External vectors from 0x40, step four
// - One more instruction may retire first
// - Interrupt number is exception number minus 16
// - Configurable exceptions disableable; fixed ones not; here supervisor call, pended service request and tick have no enable
// - Thirty external lines, 0 to 29
// - Lower priority value is more urgent
// - Configurable priorities 0 to 15
// - Ties go to lowest exception number
`ifndef CEM_DEFS_SVH
`define CEM_DEFS_SVH
`define CEM_NUM_EXC 46
`define CEM_NUM_IRQ 30
`define CEM_EXC_RESET 6'h01
`define CEM_EXC_NMI 6'h02
`define CEM_EXC_HARD 6'h03
`define CEM_EXC_MEM 6'h04
`define CEM_EXC_BUS 6'h05
`define CEM_EXC_USAGE 6'h06
`define CEM_EXC_SVC 6'h0B
`define CEM_EXC_PSR 6'h0E
`define CEM_EXC_TICK 6'h0F
`define CEM_EXC_IRQ0 6'h10
`define CEM_PRIO_NMI 6'h3E
`define CEM_PRIO_HARD 6'h3F
`define CEM_PRIO_IDLE 6'h10
`define CEM_VEC_RESET 32'h00000004
`define CEM_VEC_IRQ0 32'h00000040
`define CEM_VEC_STEP 4
`define CEM_RESERVED_MASK 46'h000000003783
`endif

/* cem_pkg.sv */
package cem_pkg;
  typedef enum logic [3:0] {
    CEM_INACTIVE = 4'b0001,
    CEM_PENDING = 4'b0010,
    CEM_ACTIVE = 4'b0100,
    CEM_ACT_PEND = 4'b1000
  } cem_state_t;
  typedef logic [5:0] cem_exc_t;
  typedef logic signed [5:0] cem_prio_t;
endpackage

/* cem_sel_if.sv */
`timescale 1ns/10ps
interface cem_sel_if;
  import cem_pkg::*;
  logic [45:0] req;
  logic [183:0] prio;
  logic found;
  cem_exc_t num;
  cem_prio_t best;
  modport core (output req, output prio, input found, input num, input best);
  modport sel (input req, input prio, output found, output num, output best);
endinterface

/* cem_select.sv */
`timescale 1ns/10ps
`include "cem_defs.svh"
module cem_select
(
  cem_sel_if.sel s
);
  import cem_pkg::*;
  // Fixed priorities win; ties keep lowest number by strict compare
  function automatic cem_prio_t prio_of(input int i, input logic [183:0] p);
    cem_prio_t r;
    r = cem_prio_t'({2'b00, p[i*4 +: 4]});
    if (i == 2)
    begin
      r = cem_prio_t'(-2);
    end
    else if (i == 3)
    begin
      r = cem_prio_t'(-1);
    end
    return r;
  endfunction
  always_comb
  begin
    s.found = 1'b0;
    s.num = 6'h00;
    s.best = cem_prio_t'(`CEM_PRIO_IDLE);
    for (int i = 2; i < `CEM_NUM_EXC; i++)
    begin
      if (s.req[i] && (!s.found || prio_of(i, s.prio) < s.best))
      begin
        s.found = 1'b1;
        s.num = cem_exc_t'(i);
        s.best = prio_of(i, s.prio);
      end
    end
  end
endmodule

/* cem_exception_unit.sv */
`timescale 1ns/10ps
`include "cem_defs.svh"
module cem_exception_unit
#(
  parameter int NUM_IRQ = `CEM_NUM_IRQ
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [29:0] irq_line,
  input wire logic [29:0] irq_set_pend,
  input wire logic [29:0] irq_enable,
  input wire logic [119:0] irq_prio,
  input wire logic nmi_line,
  input wire logic nmi_set_pend,
  input wire logic [3:0] mem_prio,
  input wire logic [3:0] bus_prio,
  input wire logic [3:0] usage_prio,
  input wire logic [3:0] svc_prio,
  input wire logic [3:0] psr_prio,
  input wire logic [3:0] tick_prio,
  input wire logic mem_enable,
  input wire logic bus_enable,
  input wire logic usage_enable,
  input wire logic mpu_violation,
  input wire logic execute_never_fetch,
  input wire logic bus_err_precise,
  input wire logic bus_err_imprecise,
  input wire logic undef_instr,
  input wire logic illegal_unaligned,
  input wire logic invalid_state,
  input wire logic bad_exc_return,
  input wire logic unaligned_access,
  input wire logic div_by_zero,
  input wire logic trap_unaligned,
  input wire logic trap_div_zero,
  input wire logic supervisor_call,
  input wire logic psr_set_pend,
  input wire logic tick_zero,
  input wire logic tick_set_pend,
  input wire logic entry_fault,
  input wire logic instr_retire,
  input wire logic take_ack,
  input wire logic exc_return,
  output logic take_req,
  output cem_pkg::cem_exc_t take_num,
  output logic [31:0] take_vector,
  output cem_pkg::cem_exc_t interrupt_program_status,
  output logic signed [6:0] irq_number,
  output logic handler_mode,
  output logic privileged,
  output logic [31:0] fetch_vector,
  output logic fetch_req,
  output logic [45:0] pend_flags,
  output logic [45:0] act_flags
);
  import cem_pkg::*;
  localparam int NE = `CEM_NUM_EXC;

  // Vector offset from exception number
  function automatic logic [31:0] vec_of(input cem_exc_t n);
    return {24'h000000, n, 2'b00};
  endfunction

  cem_sel_if sif();
  cem_state_t st [NE];
  cem_exc_t stack [NE];
  logic [5:0] depth;
  logic [29:0] irq_meta, irq_s1, irq_s2;
  logic nmi_meta, nmi_s1, nmi_s2;
  logic [29:0] irq_prev;
  logic nmi_prev;
  logic entered;

  // Line inputs cross from the pins through three flops
  always_ff @(posedge mclk)
  begin
    irq_meta <= irq_line;
    irq_s1 <= irq_meta;
    irq_s2 <= irq_s1;
    nmi_meta <= nmi_line;
    nmi_s1 <= nmi_meta;
    nmi_s2 <= nmi_s1;
  end

  // Level rises when both late stages agree high and falls only when both agree low
  wire [29:0] irq_stable = irq_s1 & irq_s2;
  wire nmi_stable = nmi_s1 & nmi_s2;
  wire [29:0] irq_rise = irq_stable & ~irq_prev;
  wire nmi_rise = nmi_stable & ~nmi_prev;

  wire mem_ev = mpu_violation | execute_never_fetch;
  wire bus_ev = bus_err_precise | bus_err_imprecise;
  wire usage_ev = undef_instr | illegal_unaligned | invalid_state | bad_exc_return
    | (unaligned_access & trap_unaligned) | (div_by_zero & trap_div_zero);
  // Disabled fault escalates to hard fault, so execute-never still aborts
  wire hard_ev = entry_fault | (mem_ev & ~mem_enable) | (bus_ev & ~bus_enable)
    | (usage_ev & ~usage_enable);

  logic [NE-1:0] raw_ev;
  logic [NE-1:0] en_mask;
  always_comb
  begin
    raw_ev = '0;
    raw_ev[`CEM_EXC_NMI] = nmi_rise | nmi_set_pend;
    raw_ev[`CEM_EXC_HARD] = hard_ev;
    raw_ev[`CEM_EXC_MEM] = mem_ev & mem_enable;
    raw_ev[`CEM_EXC_BUS] = bus_ev & bus_enable;
    raw_ev[`CEM_EXC_USAGE] = usage_ev & usage_enable;
    raw_ev[`CEM_EXC_SVC] = supervisor_call;
    raw_ev[`CEM_EXC_PSR] = psr_set_pend;
    raw_ev[`CEM_EXC_TICK] = tick_zero | tick_set_pend;
    for (int i = 0; i < NUM_IRQ; i++)
    begin
      raw_ev[16 + i] = irq_rise[i] | irq_set_pend[i];
    end
  end

  // Fixed exceptions always enabled; reserved slots never raised
  always_comb
  begin
    en_mask = '1;
    for (int i = 0; i < NUM_IRQ; i++)
    begin
      en_mask[16 + i] = irq_enable[i];
    end
  end
  wire [NE-1:0] new_ev = raw_ev & ~`CEM_RESERVED_MASK;

  logic [NE-1:0] pend_v;
  always_comb
  begin
    for (int i = 0; i < NE; i++)
    begin
      pend_v[i] = (st[i] == CEM_PENDING) || (st[i] == CEM_ACT_PEND);
    end
  end

  assign sif.req = pend_v & en_mask;
  always_comb
  begin
    sif.prio = '0;
    sif.prio[4*`CEM_EXC_MEM +: 4] = mem_prio;
    sif.prio[4*`CEM_EXC_BUS +: 4] = bus_prio;
    sif.prio[4*`CEM_EXC_USAGE +: 4] = usage_prio;
    sif.prio[4*`CEM_EXC_SVC +: 4] = svc_prio;
    sif.prio[4*`CEM_EXC_PSR +: 4] = psr_prio;
    sif.prio[4*`CEM_EXC_TICK +: 4] = tick_prio;
    sif.prio[64 +: 120] = irq_prio;
  end

  cem_select u_sel
  (
    .s(sif.sel)
  );

  // Running priority of the handler on top of the nest
  cem_prio_t run_prio;
  wire cem_exc_t top = (depth == 6'h00) ? 6'h00 : stack[depth - 6'h01];
  always_comb
  begin
    run_prio = cem_prio_t'(`CEM_PRIO_IDLE);
    if (depth != 6'h00)
    begin
      if (top == `CEM_EXC_NMI)
        run_prio = cem_prio_t'(`CEM_PRIO_NMI);
      else if (top == `CEM_EXC_HARD)
        run_prio = cem_prio_t'(`CEM_PRIO_HARD);
      else
        run_prio = cem_prio_t'({2'b00, sif.prio[top*4 +: 4]});
    end
  end
  // Equal priority never preempts
  wire can_take = sif.found && (sif.best < run_prio);
  wire do_take = take_req && take_ack;
  wire do_ret = exc_return && (depth != 6'h00) && !do_take;

  // Per-source four state tracking; new request beats service changes
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < NE; i++)
    begin
      if (rst)
        st[i] <= CEM_INACTIVE;
      else
      begin
        unique case (st[i])
          CEM_INACTIVE:
            if (new_ev[i]) st[i] <= CEM_PENDING;
          CEM_PENDING:
            if (do_take && take_num == cem_exc_t'(i))
              st[i] <= new_ev[i] ? CEM_ACT_PEND : CEM_ACTIVE;
          CEM_ACTIVE:
            if (do_ret && top == cem_exc_t'(i))
              st[i] <= new_ev[i] ? CEM_PENDING : CEM_INACTIVE;
            else if (new_ev[i]) st[i] <= CEM_ACT_PEND;
          CEM_ACT_PEND:
            if (do_ret && top == cem_exc_t'(i)) st[i] <= CEM_PENDING;
          default:
            st[i] <= CEM_INACTIVE;
        endcase
      end
    end
  end

  // Nest stack keeps every preempted handler active
  always_ff @(posedge mclk)
  begin
    if (rst)
      depth <= 6'h00;
    else if (do_take)
    begin
      stack[depth] <= take_num;
      depth <= depth + 6'h01;
    end
    else if (do_ret)
      depth <= depth - 6'h01;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_prev <= '0;
      nmi_prev <= 1'b0;
    end
    else
    begin
      irq_prev <= irq_stable | (irq_prev & (irq_s1 | irq_s2));
      nmi_prev <= nmi_stable | (nmi_prev & (nmi_s1 | nmi_s2));
    end
  end

  // Request follows can_take and drops on ack or exception return; an instruction may retire meanwhile
  always_ff @(posedge mclk)
  begin
    if (rst || do_take || do_ret)
      take_req <= 1'b0;
    else
      take_req <= can_take;
    if (rst)
    begin
      take_num <= 6'h00;
      take_vector <= 32'h00000000;
    end
    else if (!take_req || !can_take)
    begin
      take_num <= sif.num;
      take_vector <= vec_of(sif.num);
    end
  end

  // Reset restart: vector fetch, privileged, thread mode
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fetch_req <= 1'b0;
      fetch_vector <= 32'h00000000;
      entered <= 1'b0;
      privileged <= 1'b1;
    end
    else
    begin
      entered <= 1'b1;
      fetch_req <= !entered;
      fetch_vector <= `CEM_VEC_RESET;
      privileged <= 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      handler_mode <= 1'b0;
      interrupt_program_status <= 6'h00;
      irq_number <= 7'sh00;
      pend_flags <= '0;
      act_flags <= '0;
    end
    else
    begin
      handler_mode <= (depth != 6'h00);
      interrupt_program_status <= top;
      irq_number <= $signed({1'b0, top}) - 7'sd16;
      pend_flags <= pend_v;
      for (int i = 0; i < NE; i++)
      begin
        act_flags[i] <= (st[i] == CEM_ACTIVE) || (st[i] == CEM_ACT_PEND);
      end
    end
  end

  property p_set_pend;
    @(posedge mclk) disable iff (rst) new_ev[`CEM_EXC_PSR] && st[`CEM_EXC_PSR] == CEM_INACTIVE
      |=> st[`CEM_EXC_PSR] == CEM_PENDING;
  endproperty
  a_set_pend: assert property (p_set_pend) else $error("request did not pend");
  property p_act_pend;
    @(posedge mclk) disable iff (rst) st[`CEM_EXC_IRQ0] == CEM_ACTIVE && new_ev[`CEM_EXC_IRQ0]
      && !(do_ret && top == `CEM_EXC_IRQ0) |=> st[`CEM_EXC_IRQ0] == CEM_ACT_PEND;
  endproperty
  a_act_pend: assert property (p_act_pend) else $error("request while active lost");
  property p_nmi_first;
    @(posedge mclk) disable iff (rst) sif.req[`CEM_EXC_NMI] |-> sif.num == `CEM_EXC_NMI;
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("nmi not chosen");
  property p_vector;
    @(posedge mclk) disable iff (rst) take_req |-> take_vector == `CEM_VEC_IRQ0
      - 32'(`CEM_EXC_IRQ0) * `CEM_VEC_STEP + 32'(take_num) * `CEM_VEC_STEP;
  endproperty
  a_vector: assert property (p_vector) else $error("vector offset wrong");
  property p_reserved;
    @(posedge mclk) disable iff (rst) take_req |-> !(take_num inside {7, 8, 9, 10, 12, 13});
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved exception taken");
  property p_restart;
    @(posedge mclk) $fell(rst) |=> fetch_req && fetch_vector == 32'h00000004 && privileged && !handler_mode;
  endproperty
  a_restart: assert property (p_restart) else $error("restart wrong");
  property p_nest;
    @(posedge mclk) disable iff (rst) do_take && depth != 6'h00 |=> ##1 handler_mode && act_flags[stack[0]];
  endproperty
  a_nest: assert property (p_nest) else $error("nested handler lost");
  property p_interrupt_program_status;
    @(posedge mclk) disable iff (rst) do_take |=> ##1 interrupt_program_status == $past(take_num, 2);
  endproperty
  a_interrupt_program_status: assert property (p_interrupt_program_status) else $error("status number wrong");
  c_take: cover property (@(posedge mclk) disable iff (rst) do_take);
  c_nest: cover property (@(posedge mclk) disable iff (rst) do_take && depth == 6'h01);
  c_actpend: cover property (@(posedge mclk) disable iff (rst) st[16] == CEM_ACT_PEND);
endmodule

/* cem_partner.sv */
`timescale 1ns/10ps
module cem_partner
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic take_req,
  input wire logic handler_mode,
  input wire logic slow,
  input wire logic ret_cmd,
  output logic take_ack,
  output logic exc_return
);
  logic [2:0] wait_cnt;
  wire ack_ok = !slow || wait_cnt == 3'h3;
  // Pipeline model: acks only a standing request, returns only in handler mode
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      take_ack <= 1'b0;
      exc_return <= 1'b0;
      wait_cnt <= 3'h0;
    end
    else
    begin
      take_ack <= take_req && !take_ack && ack_ok;
      wait_cnt <= (take_req && !take_ack) ? wait_cnt + 3'h1 : 3'h0;
      exc_return <= ret_cmd && handler_mode && !exc_return;
    end
  end
endmodule

/* tb.sv */
`timescale 1ns/10ps
module tb import cem_pkg::*;;
  logic mclk, rst, nmi_line, trap_unaligned, trap_div_zero, slow, ret_cmd;
  logic mem_enable, bus_enable, usage_enable, take_ack, exc_return;
  logic [29:0] irq_line, irq_set_pend, irq_enable;
  logic [119:0] irq_prio;
  logic [23:0] sp;
  logic [15:0] ev;
  logic take_req, handler_mode, privileged, fetch_req;
  cem_exc_t take_num, interrupt_program_status;
  logic [31:0] take_vector, fetch_vector;
  logic signed [6:0] irq_number;
  logic [45:0] pend_flags, act_flags;
  int n_fail = 0;
  int total_checks = 0;

  cem_exception_unit cem_exception_unit_i (.mclk, .rst, .irq_line, .irq_set_pend, .irq_enable, .irq_prio,
    .nmi_line, .nmi_set_pend(ev[13]), .mem_prio(sp[3:0]), .bus_prio(sp[7:4]), .usage_prio(sp[11:8]),
    .svc_prio(sp[15:12]), .psr_prio(sp[19:16]), .tick_prio(sp[23:20]), .mem_enable, .bus_enable,
    .usage_enable, .mpu_violation(ev[0]), .execute_never_fetch(ev[1]), .bus_err_precise(ev[2]),
    .bus_err_imprecise(ev[3]), .undef_instr(ev[4]), .illegal_unaligned(ev[5]), .invalid_state(ev[6]),
    .bad_exc_return(ev[7]), .unaligned_access(ev[8]), .div_by_zero(ev[9]), .trap_unaligned,
    .trap_div_zero, .supervisor_call(ev[10]), .psr_set_pend(ev[14]), .tick_zero(ev[11]),
    .tick_set_pend(ev[15]), .entry_fault(ev[12]), .instr_retire(1'b0), .take_ack, .exc_return,
    .take_req, .take_num, .take_vector, .interrupt_program_status, .irq_number, .handler_mode,
    .privileged, .fetch_vector, .fetch_req, .pend_flags, .act_flags);
  cem_partner cem_partner_i (.mclk, .rst, .take_req, .handler_mode, .slow, .ret_cmd, .take_ack,
    .exc_return);

  task test_done;
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task fire(input int k);
    @(posedge mclk);
    ev <= 16'h0001 << k;
    @(posedge mclk);
    ev <= 16'h0000;
  endtask

  task pend_irq(input logic [29:0] m);
    @(posedge mclk);
    irq_set_pend <= m;
    @(posedge mclk);
    irq_set_pend <= 30'h0;
  endtask

  task take_one(input int n);
    int i;
    for (i = 0; i < 40 && take_req !== 1'b1; i++)
      @(negedge mclk);
    chk("take_req", take_req, 1);
    chk("take_num", take_num, n);
    chk("take_vector", take_vector, 4 * n);
    for (i = 0; i < 40 && act_flags[n] !== 1'b1; i++)
      @(negedge mclk);
    @(negedge mclk);
    chk("act", act_flags[n], 1);
    chk("status", interrupt_program_status, n);
    chk("irq_number", 32'(irq_number), n - 16);
    chk("mode", handler_mode, 1);
  endtask

  task ret_pulse;
    @(posedge mclk);
    ret_cmd <= 1'b1;
    @(posedge mclk);
    ret_cmd <= 1'b0;
  endtask

  task ret_one(input int n);
    int i;
    ret_pulse;
    for (i = 0; i < 20 && act_flags[n] !== 1'b0; i++)
      @(negedge mclk);
    @(negedge mclk);
    chk("inactive", {pend_flags[n], act_flags[n]}, 0);
  endtask

  task t_reset;
    @(negedge mclk);
    chk("priv_rst", privileged, 1);
    chk("req_rst", take_req, 0);
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    chk("fetch_req", fetch_req, 1);
    chk("fetch_vector", fetch_vector, 32'h00000004);
    chk("thread", handler_mode, 0);
  endtask

  task t_psr;
    int i;
    @(posedge mclk);
    slow <= 1'b1;
    fire(14);
    for (i = 0; i < 5 && pend_flags[14] !== 1'b1; i++)
      @(negedge mclk);
    chk("pend", pend_flags[14], 1);
    chk("not_act", act_flags[14], 0);
    take_one(14);
    ret_one(14);
    @(posedge mclk);
    slow <= 1'b0;
  endtask

  task t_sys;
    int k;
    int en[16] = '{4, 4, 5, 5, 6, 6, 6, 6, 6, 6, 11, 15, 3, 2, 14, 15};
    for (k = 0; k < 16; k++)
    begin
      fire(k);
      take_one(en[k]);
      ret_one(en[k]);
    end
    @(posedge mclk);
    trap_div_zero <= 1'b0;
    fire(9);
    repeat (10) @(negedge mclk);
    chk("no_trap", {take_req, pend_flags[6]}, 0);
    @(posedge mclk);
    mem_enable <= 1'b0;
    fire(1);
    take_one(3);
    ret_one(3);
    @(posedge mclk);
    mem_enable <= 1'b1;
  endtask

  task t_nest;
    fire(14);
    take_one(14);
    @(posedge mclk);
    irq_prio[3:0] <= 4'h2;
    pend_irq(30'h1);
    take_one(16);
    chk("nested", act_flags[14], 1);
    pend_irq(30'h1);
    repeat (3) @(negedge mclk);
    chk("act_pend", {pend_flags[16], act_flags[16]}, 3);
    chk("no_preempt", take_req, 0);
    ret_pulse;
    take_one(16);
    ret_one(16);
    ret_one(14);
    @(posedge mclk);
    irq_prio[3:0] <= 4'h8;
  endtask

  task t_irq;
    pend_irq(30'hA);
    take_one(17);
    ret_pulse;
    take_one(19);
    ret_one(19);
    @(posedge mclk);
    irq_enable[2] <= 1'b0;
    pend_irq(30'h4);
    repeat (10) @(negedge mclk);
    chk("masked", {pend_flags[18], take_req}, 2);
    @(posedge mclk);
    irq_enable[2] <= 1'b1;
    take_one(18);
    ret_one(18);
    @(posedge mclk);
    irq_line[29] <= 1'b1;
    take_one(45);
    ret_one(45);
    @(posedge mclk);
    nmi_line <= 1'b1;
    take_one(2);
    ret_one(2);
    chk("reserved", 32'((pend_flags | act_flags) & 46'h000000003780), 0);
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    test_done;
  end

  initial
  begin
    rst = 1'b1;
    nmi_line = 1'b0;
    trap_unaligned = 1'b1;
    trap_div_zero = 1'b1;
    slow = 1'b0;
    ret_cmd = 1'b0;
    mem_enable = 1'b1;
    bus_enable = 1'b1;
    usage_enable = 1'b1;
    irq_line = 30'h0;
    irq_set_pend = 30'h0;
    irq_enable = 30'h3FFFFFFF;
    irq_prio = {30{4'h8}};
    sp = 24'h888888;
    ev = 16'h0000;
    repeat (5) @(posedge mclk);
    t_reset;
    t_psr;
    t_sys;
    t_nest;
    t_irq;
    test_done;
  end
endmodule
